// >>> ext_irq_pkg.sv
// Shared constants, register map and types for the external pin interrupt unit.
package ext_irq_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] ADDR_SENSE_CONTROL  = 6'h10;
  localparam logic [5:0] ADDR_ENABLE_MASK    = 6'h11;
  localparam logic [5:0] ADDR_PC_GROUP0_MASK = 6'h12;
  localparam logic [5:0] ADDR_FLAG_STATUS    = 6'h13;
  localparam logic [5:0] ADDR_PC_GROUP1_MASK = 6'h14;

  localparam int SENSE_SELECT_LOW_BIT  = 0;
  localparam int SENSE_SELECT_HIGH_BIT = 1;
  localparam int EXT_IRQ_ZERO_BIT      = 6;
  localparam int PC_GROUP1_BIT         = 5;
  localparam int PC_GROUP0_BIT         = 4;

  localparam int PIN_CHANGE_COUNT  = 12;
  localparam int PC_GROUP0_WIDTH   = 8;
  localparam int PC_GROUP1_WIDTH   = 4;

  localparam logic [7:0] RESET_REG  = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  typedef logic [1:0] sense_t;
  localparam sense_t SENSE_LOW_LEVEL = 2'h0;
  localparam sense_t SENSE_ANY_CHANGE = 2'h1;
  localparam sense_t SENSE_FALLING    = 2'h2;
  localparam sense_t SENSE_RISING     = 2'h3;

  localparam logic [15:0] VEC_NONE          = 16'h0000;
  localparam logic [15:0] VEC_EXT_IRQ_ZERO  = 16'h0001;
  localparam logic [15:0] VEC_PC_GROUP0     = 16'h0002;
  localparam logic [15:0] VEC_PC_GROUP1     = 16'h0003;

  typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_PC0, SRC_PC1} irq_src_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } reg_req_t;

endpackage

// >>> external_pin_interrupts.sv
// External interrupt pin and pin-change interrupt unit with its registers and vector request.
//
// What this block does
// - Dedicated interrupt requests only with global flag and its enable both set.
// - Sense bits 1:0 select low level, any change, falling or rising edge.
// - Pin is sampled before edge detection; pulses over two clocks are caught.
// - Pin activity requests even when the pin is driven as an output.
// - Enable register bit 6 enables the dedicated pin at its own vector.
// - Enable bit 5 enables group one, inputs 11 to 8, at its vector.
// - Enable bit 4 enables group zero, inputs 7 to 0, at its vector.
// - Group-one mask bits 3:0 enable inputs 11 to 8 with the group enable.
// - Group-zero mask bits 7:0 enable inputs 7 to 0; cleared bit disables.
// - Flag bit 6 sets when an edge or change on the pin triggers.
// - Flags clear on vector entry or by writing one; zero leaves them.
// - In low-level mode the dedicated pin flag always reads as cleared.
// - Flag bit 5 sets on an enabled change of inputs 11 to 8.
// - Flag bit 4 sets on an enabled change of inputs 7 to 0.
// - Reserved bits of enable, flag and group-one mask registers read zero.
// - Vectors are 0x0001 for the pin, 0x0002 group zero, 0x0003 group one.
// - Pin-change detection serves as a wake-up source outside idle.
// - Low level gives wake-up; edges need the running clock.
// - Level mode keeps requesting for as long as the pin stays low.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupts
  import ext_irq_pkg::*;
#(
  parameter int VECTOR_WIDTH = 16
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire reg_req_t                    regReq,
  output var  logic [DATA_W-1:0]           rdData,
  input  wire logic                        extIrqPin,
  input  wire logic [PIN_CHANGE_COUNT-1:0] pinChangeInputs,
  input  wire logic                        globalIntEnable,
  input  wire logic                        intAck,
  output var  logic                        intRequest,
  output var  logic [VECTOR_WIDTH-1:0]     intVector,
  output var  logic                        wakeRequest
);

  initial begin
    if (VECTOR_WIDTH < 2 || VECTOR_WIDTH > 16) $error("external_pin_interrupts: VECTOR_WIDTH must be 2 to 16");
  end

  sense_t                       senseMode;
  logic                         extEnable;
  logic                         pcGroup1Enable;
  logic                         pcGroup0Enable;
  logic [PC_GROUP0_WIDTH-1:0]   pcGroup0Mask;
  logic [PC_GROUP1_WIDTH-1:0]   pcGroup1Mask;
  logic                         extFlag;
  logic                         pcGroup1Flag;
  logic                         pcGroup0Flag;
  irq_src_t                     presentedSrc;
  logic                         extLevel;
  logic                         extChanged;
  logic [PIN_CHANGE_COUNT-1:0]  pcChanged;
  logic                         levelMode;
  logic                         extEvent;
  logic                         pc0Event;
  logic                         pc1Event;
  logic                         flagWrite;
  logic                         extPending;
  logic                         pc0Pending;
  logic                         pc1Pending;
  irq_src_t                     next_src;
  logic [DATA_W-1:0]            next_rdData;

  // The pin is read whatever its direction, so driving it as an output triggers too.
  input_sync #(.WIDTH(1)) u_ext_sync (
    .clk     (clk),
    .resetn  (resetn),
    .pinIn   (extIrqPin),
    .level   (extLevel),
    .changed (extChanged)
  );

  input_sync #(.WIDTH(PIN_CHANGE_COUNT)) u_pc_sync (
    .clk     (clk),
    .resetn  (resetn),
    .pinIn   (pinChangeInputs),
    .level   (),
    .changed (pcChanged)
  );

  assign levelMode = (senseMode == SENSE_LOW_LEVEL);
  assign flagWrite = regReq.wrEn && (regReq.addr == ADDR_FLAG_STATUS);

  // Edge selection for the dedicated pin.
  always_comb begin
    case (senseMode)
      SENSE_ANY_CHANGE: extEvent = extChanged;
      SENSE_FALLING:    extEvent = extChanged && !extLevel;
      SENSE_RISING:     extEvent = extChanged && extLevel;
      default:          extEvent = 1'b0;
    endcase
  end

  // An input contributes only with its mask bit and its group enable set.
  assign pc0Event = pcGroup0Enable && |(pcChanged[PC_GROUP0_WIDTH-1:0] & pcGroup0Mask);
  assign pc1Event = pcGroup1Enable && |(pcChanged[PIN_CHANGE_COUNT-1:PC_GROUP0_WIDTH] & pcGroup1Mask);

  // Control registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      senseMode      <= SENSE_LOW_LEVEL;
      extEnable      <= 1'b0;
      pcGroup1Enable <= 1'b0;
      pcGroup0Enable <= 1'b0;
      pcGroup0Mask   <= '0;
      pcGroup1Mask   <= '0;
    end else if (regReq.wrEn) begin
      if (regReq.addr == ADDR_SENSE_CONTROL) begin
        senseMode <= regReq.wrData[SENSE_SELECT_HIGH_BIT:SENSE_SELECT_LOW_BIT];
      end else if (regReq.addr == ADDR_ENABLE_MASK) begin
        extEnable      <= regReq.wrData[EXT_IRQ_ZERO_BIT];
        pcGroup1Enable <= regReq.wrData[PC_GROUP1_BIT];
        pcGroup0Enable <= regReq.wrData[PC_GROUP0_BIT];
      end else if (regReq.addr == ADDR_PC_GROUP0_MASK) begin
        pcGroup0Mask <= regReq.wrData[PC_GROUP0_WIDTH-1:0];
      end else if (regReq.addr == ADDR_PC_GROUP1_MASK) begin
        pcGroup1Mask <= regReq.wrData[PC_GROUP1_WIDTH-1:0];
      end
    end
  end

  // Flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extFlag <= 1'b0;
    end else if (levelMode) begin
      extFlag <= 1'b0;
    end else if (extEvent) begin
      extFlag <= 1'b1;
    end else if ((flagWrite && regReq.wrData[EXT_IRQ_ZERO_BIT]) || (intAck && presentedSrc == SRC_EXT)) begin
      extFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcGroup0Flag <= 1'b0;
    end else if (pc0Event) begin
      pcGroup0Flag <= 1'b1;
    end else if ((flagWrite && regReq.wrData[PC_GROUP0_BIT]) || (intAck && presentedSrc == SRC_PC0)) begin
      pcGroup0Flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcGroup1Flag <= 1'b0;
    end else if (pc1Event) begin
      pcGroup1Flag <= 1'b1;
    end else if ((flagWrite && regReq.wrData[PC_GROUP1_BIT]) || (intAck && presentedSrc == SRC_PC1)) begin
      pcGroup1Flag <= 1'b0;
    end
  end

  // Requests are gated by the global flag and each source's enable.
  assign extPending = globalIntEnable && extEnable && (levelMode ? !extLevel : extFlag);
  assign pc0Pending = globalIntEnable && pcGroup0Enable && pcGroup0Flag;
  assign pc1Pending = globalIntEnable && pcGroup1Enable && pcGroup1Flag;

  // Lowest vector first.
  always_comb begin
    if (extPending) begin
      next_src = SRC_EXT;
    end else if (pc0Pending) begin
      next_src = SRC_PC0;
    end else if (pc1Pending) begin
      next_src = SRC_PC1;
    end else begin
      next_src = SRC_NONE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presentedSrc <= SRC_NONE;
      intRequest   <= 1'b0;
      intVector    <= '0;
    end else begin
      presentedSrc <= next_src;
      intRequest   <= (next_src != SRC_NONE);
      case (next_src)
        SRC_EXT: intVector <= VEC_EXT_IRQ_ZERO[VECTOR_WIDTH-1:0];
        SRC_PC0: intVector <= VEC_PC_GROUP0[VECTOR_WIDTH-1:0];
        SRC_PC1: intVector <= VEC_PC_GROUP1[VECTOR_WIDTH-1:0];
        default: intVector <= VEC_NONE[VECTOR_WIDTH-1:0];
      endcase
    end
  end

  // Wake-up ignores the global flag; a held low level or any pending pin change wakes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= (extEnable && levelMode && !extLevel) || (pcGroup0Enable && pcGroup0Flag) ||
                     (pcGroup1Enable && pcGroup1Flag);
    end
  end

  // Register read decode; unmapped addresses and reserved bits read zero.
  always_comb begin
    next_rdData = READ_ZERO;
    if (regReq.addr == ADDR_SENSE_CONTROL) begin
      next_rdData[SENSE_SELECT_HIGH_BIT:SENSE_SELECT_LOW_BIT] = senseMode;
    end else if (regReq.addr == ADDR_ENABLE_MASK) begin
      next_rdData[EXT_IRQ_ZERO_BIT] = extEnable;
      next_rdData[PC_GROUP1_BIT]    = pcGroup1Enable;
      next_rdData[PC_GROUP0_BIT]    = pcGroup0Enable;
    end else if (regReq.addr == ADDR_FLAG_STATUS) begin
      next_rdData[EXT_IRQ_ZERO_BIT] = extFlag && !levelMode;
      next_rdData[PC_GROUP1_BIT]    = pcGroup1Flag;
      next_rdData[PC_GROUP0_BIT]    = pcGroup0Flag;
    end else if (regReq.addr == ADDR_PC_GROUP0_MASK) begin
      next_rdData[PC_GROUP0_WIDTH-1:0] = pcGroup0Mask;
    end else if (regReq.addr == ADDR_PC_GROUP1_MASK) begin
      next_rdData[PC_GROUP1_WIDTH-1:0] = pcGroup1Mask;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= READ_ZERO;
    end else begin
      rdData <= regReq.rdEn ? next_rdData : READ_ZERO;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_req_needs_global: assert property (intRequest |-> $past(globalIntEnable))
    else $error("request raised without global enable");

  a_level_flag_clear: assert property ($past(levelMode) |-> !extFlag)
    else $error("pin flag set in level mode");

  a_level_holds_req: assert property (
    (levelMode && extEnable && globalIntEnable && !extLevel) |=> (intRequest && intVector == VEC_EXT_IRQ_ZERO[VECTOR_WIDTH-1:0]))
    else $error("level request not held");

  a_falling_sets_flag: assert property ((senseMode == SENSE_FALLING && extChanged && !extLevel) |=> extFlag)
    else $error("falling edge did not set pin flag");

  a_rising_ignored: assert property (
    (senseMode == SENSE_FALLING && !extFlag && !(extChanged && !extLevel)) |=> !extFlag)
    else $error("pin flag set without falling edge");

  a_group0_sets: assert property (pc0Event |=> pcGroup0Flag)
    else $error("group zero change did not set flag");

  a_group1_sets: assert property (pc1Event |=> pcGroup1Flag)
    else $error("group one change did not set flag");

  a_mask_blocks: assert property (
    (!pcGroup0Flag && !(|(pcChanged[PC_GROUP0_WIDTH-1:0] & pcGroup0Mask))) |=> !pcGroup0Flag)
    else $error("masked input set group zero flag");

  a_write_one_clears: assert property ((flagWrite && regReq.wrData[PC_GROUP1_BIT] && !pc1Event) |=> !pcGroup1Flag)
    else $error("write one did not clear group one flag");

  a_lowest_first: assert property ((extPending && pc0Pending) |=> intVector == VEC_EXT_IRQ_ZERO[VECTOR_WIDTH-1:0])
    else $error("lower vector not presented first");

  a_pin_gated: assert property (
    (intRequest && intVector == VEC_EXT_IRQ_ZERO[VECTOR_WIDTH-1:0]) |-> $past(extPending))
    else $error("pin request without its enable");

  a_group0_gated: assert property (
    (intRequest && intVector == VEC_PC_GROUP0[VECTOR_WIDTH-1:0]) |-> $past(pc0Pending))
    else $error("group zero request without its enable");

  a_group1_gated: assert property (
    (intRequest && intVector == VEC_PC_GROUP1[VECTOR_WIDTH-1:0]) |-> $past(pc1Pending))
    else $error("group one request without its enable");

  a_vector_group1: assert property (
    (presentedSrc == SRC_PC1) |-> (intVector == VEC_PC_GROUP1[VECTOR_WIDTH-1:0]))
    else $error("group one vector wrong");

  a_ack_clears: assert property (
    (intAck && presentedSrc == SRC_PC0 && !pc0Event) |=> !pcGroup0Flag)
    else $error("acknowledge did not clear group zero flag");

  a_group1_masked: assert property (
    (!pcGroup1Flag && !(|(pcChanged[PIN_CHANGE_COUNT-1:PC_GROUP0_WIDTH] & pcGroup1Mask))) |=> !pcGroup1Flag)
    else $error("masked input set group one flag");

  a_reserved_zero: assert property (
    (regReq.rdEn && (regReq.addr == ADDR_FLAG_STATUS || regReq.addr == ADDR_ENABLE_MASK)) |=>
      (rdData[7] == 1'b0 && rdData[3:0] == 4'h0))
    else $error("reserved bit read as one");

  a_mask1_upper: assert property (
    (regReq.rdEn && regReq.addr == ADDR_PC_GROUP1_MASK) |=> (rdData[7:4] == 4'h0))
    else $error("group one mask upper bits read as one");

  c_edge_request: cover property (extEvent ##1 extFlag ##[1:3] intRequest);
  c_group0_ack: cover property (pcGroup0Flag && intAck && presentedSrc == SRC_PC0 ##1 !pcGroup0Flag);
  c_level_request: cover property (levelMode && intRequest);
  c_group1_request: cover property (pc1Event ##2 intRequest);

endmodule
`default_nettype wire

// >>> input_sync.sv
// Three-stage pin synchroniser with a settled level and a one-cycle change pulse.
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] level,
  output var  logic [WIDTH-1:0] changed
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial begin
    if (WIDTH < 1) $error("input_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A new level is accepted only once the second and third stages agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          level[i]   <= 1'b0;
          changed[i] <= 1'b0;
        end else begin
          changed[i] <= (stage2[i] == stage3[i]) && (stage3[i] != level[i]);
          if (stage2[i] == stage3[i]) begin
            level[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> pin_source_model.sv
// Behavioural source of the dedicated interrupt pin and the twelve pin-change lines.
`timescale 1ns/1ps
`default_nettype none
module pin_source_model
  import ext_irq_pkg::*;
(
  input  wire logic                        clk,
  output var  logic                        extIrqPin,
  output var  logic [PIN_CHANGE_COUNT-1:0] pinChangeInputs
);
  initial begin
    extIrqPin       = 1'b0;
    pinChangeInputs = '0;
  end

  // Levels change just after a rising edge and then stand for whole cycles.
  task automatic setPin(input logic v);
    @(posedge clk);
    extIrqPin <= v;
  endtask

  task automatic setInputs(input logic [PIN_CHANGE_COUNT-1:0] v);
    @(posedge clk);
    pinChangeInputs <= v;
  endtask

  // A low level is held for whole cycles so that the request can be seen.
  task automatic holdLow(input int cycles);
    setPin(1'b0);
    repeat (cycles) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test_external_pin_interrupts.sv
// Self-checking testbench for the external pin interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_interrupts
  import ext_irq_pkg::*;
;
  logic        clk;
  logic        resetn;
  reg_req_t    regReq;
  logic [7:0]  rdData;
  logic        extIrqPin;
  logic [11:0] pinChangeInputs;
  logic        gie;
  logic        intAck;
  logic        intRequest;
  logic [15:0] intVector;
  logic        wakeRequest;
  int          bad_count;
  int          check_count;
  logic        f;
  logic        g;
  logic [7:0]  m0;
  logic [7:0]  m1;
  logic [7:0]  en;
  logic [7:0]  fl;
  logic [11:0] tog;
  logic [11:0] cur;

  external_pin_interrupts dut (.clk(clk), .resetn(resetn), .regReq(regReq), .rdData(rdData),
    .extIrqPin(extIrqPin), .pinChangeInputs(pinChangeInputs), .globalIntEnable(gie),
    .intAck(intAck), .intRequest(intRequest), .intVector(intVector), .wakeRequest(wakeRequest));
  pin_source_model pins (.clk(clk), .extIrqPin(extIrqPin), .pinChangeInputs(pinChangeInputs));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  // The vector is only compared while a request is expected.
  task automatic chkIrq(input logic req, input logic [15:0] vec, input logic wake);
    check_count++;
    if (intRequest !== req || wakeRequest !== wake || (req && intVector !== vec)) begin
      bad_count++;
      $display("BAD %0t request %b vector %h wake %b", $time, intRequest, intVector, wakeRequest);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge clk);
    regReq.wrEn <= 1'b0;
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge clk);
    regReq.rdEn <= 1'b0;
    #1;
    chkReg(rdData, exp);
  endtask

  task automatic ack();
    @(posedge clk);
    intAck <= 1'b1;
    @(posedge clk);
    intAck <= 1'b0;
    settle(3);
  endtask

  function automatic logic expPin(input sense_t m, input logic rising);
    return m == SENSE_ANY_CHANGE || m == (rising ? SENSE_RISING : SENSE_FALLING);
  endfunction

  function automatic logic [7:0] expGroup(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] e,
                                          input logic [11:0] t);
    return {2'b00, e[PC_GROUP1_BIT] & |(k1[3:0] & t[11:8]), e[PC_GROUP0_BIT] & |(k0 & t[7:0]), 4'h0};
  endfunction

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    regReq = '0;
    gie    = 1'b0;
    intAck = 1'b0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'hBB67E7C3));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 16; a < 22; a++) rdChk(6'(a), 8'h00);
    pins.setPin(1'b1);
    settle(8);
    wr(ADDR_ENABLE_MASK, 8'hFF);
    rdChk(ADDR_ENABLE_MASK, 8'h70);
    wr(ADDR_PC_GROUP1_MASK, 8'hFF);
    rdChk(ADDR_PC_GROUP1_MASK, 8'h0F);
    wr(ADDR_FLAG_STATUS, 8'hFF);
    rdChk(ADDR_FLAG_STATUS, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_SENSE_CONTROL, 8'(m));
      wr(ADDR_ENABLE_MASK, 8'h40);
      gie <= 1'b0;
      pins.setPin(1'b0);
      settle(8);
      f = expPin(sense_t'(m), 1'b0);
      rdChk(ADDR_FLAG_STATUS, {1'b0, f, 6'h00});
      chkIrq(1'b0, VEC_NONE, 1'b0);
      wr(ADDR_FLAG_STATUS, 8'h00);
      rdChk(ADDR_FLAG_STATUS, {1'b0, f, 6'h00});
      gie <= 1'b1;
      settle(3);
      chkIrq(f, VEC_EXT_IRQ_ZERO, 1'b0);
      wr(ADDR_FLAG_STATUS, 8'h40);
      rdChk(ADDR_FLAG_STATUS, 8'h00);
      pins.setPin(1'b1);
      settle(8);
      f = expPin(sense_t'(m), 1'b1);
      chkIrq(f, VEC_EXT_IRQ_ZERO, 1'b0);
      ack();
      chkIrq(1'b0, VEC_NONE, 1'b0);
    end
    wr(ADDR_SENSE_CONTROL, 8'h00);
    pins.holdLow(8);
    settle(0);
    chkIrq(1'b1, VEC_EXT_IRQ_ZERO, 1'b1);
    rdChk(ADDR_FLAG_STATUS, 8'h00);
    gie <= 1'b0;
    settle(3);
    chkIrq(1'b0, VEC_NONE, 1'b1);
    gie <= 1'b1;
    pins.setPin(1'b1);
    settle(8);
    chkIrq(1'b0, VEC_NONE, 1'b0);
    wr(ADDR_SENSE_CONTROL, 8'h03);
    cur = '0;
    for (int i = 0; i < 16; i++) begin
      m0 = 8'($urandom);
      m1 = 8'($urandom);
      en = 8'($urandom) & 8'h30;
      tog = 12'($urandom);
      g = 1'($urandom);
      if (i == 0) begin
        m0 = 8'h00;
        en = 8'h30;
        tog = 12'h0FF;
        g = 1'b1;
      end
      wr(ADDR_PC_GROUP0_MASK, m0);
      wr(ADDR_PC_GROUP1_MASK, m1);
      wr(ADDR_ENABLE_MASK, en);
      gie <= g;
      cur = cur ^ tog;
      pins.setInputs(cur);
      settle(8);
      fl = expGroup(m0, m1, en, tog);
      rdChk(ADDR_FLAG_STATUS, fl);
      chkIrq(g && |fl, fl[4] ? VEC_PC_GROUP0 : VEC_PC_GROUP1, |fl);
      wr(ADDR_FLAG_STATUS, 8'h30);
      settle(3);
    end
    gie <= 1'b1;
    wr(ADDR_SENSE_CONTROL, 8'h01);
    wr(ADDR_PC_GROUP0_MASK, 8'h01);
    wr(ADDR_PC_GROUP1_MASK, 8'h0F);
    wr(ADDR_ENABLE_MASK, 8'h70);
    pins.setPin(1'b0);
    cur = cur ^ 12'h101;
    pins.setInputs(cur);
    settle(8);
    rdChk(ADDR_FLAG_STATUS, 8'h70);
    chkIrq(1'b1, VEC_EXT_IRQ_ZERO, 1'b1);
    ack();
    chkIrq(1'b1, VEC_PC_GROUP0, 1'b1);
    ack();
    chkIrq(1'b1, VEC_PC_GROUP1, 1'b1);
    ack();
    chkIrq(1'b0, VEC_NONE, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
